//--- pio_byte_pkg.sv
// Constants and carrier types for the parallel I/O byte register bank
//
// Behaviour
// - Read location 0 returns 1 when a further transfer can be accepted, else 0.
// - Read location 1 always returns the fixed card-type code.
// - Write 3 holds irq enable and DMA bits; read 3 adds pending and priority.
// - Read location 4 returns input word bits 15 down to 8.
// - Read location 5 returns input word bits 7 down to 0.
// - Write location 4 loads output word bits 15 down to 8.
// - Write location 5 loads output word bits 7 down to 0.
// - Non-zero write to location 0 sets the handshake line; zero does nothing.
// - Non-zero write to location 1 resets the interface logic.
// - Write 7 bits 1:0 drive control outputs; 1 drives low; rest ignored.
// - Write location 2 accepts the interrupt mask byte.
// - Read 7 gives peripheral-OK, line-low flags in bits 3:0; 7:4 zero.
// - Peripheral status bits show live line levels, never latched.
// - Control outputs keep last written level; interface reset leaves them.
package pio_byte_pkg;

    // ------------------------------------------------------------
    // Byte locations
    // ------------------------------------------------------------
    localparam logic [2:0] LOC_READY_SET = 3'h0;
    localparam logic [2:0] LOC_ID_RESET = 3'h1;
    localparam logic [2:0] LOC_MASK = 3'h2;
    localparam logic [2:0] LOC_IRQ_DMA = 3'h3;
    localparam logic [2:0] LOC_WORD_HIGH = 3'h4;
    localparam logic [2:0] LOC_WORD_LOW = 3'h5;
    localparam logic [2:0] LOC_UNUSED = 3'h6;
    localparam logic [2:0] LOC_LINES = 3'h7;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_IRQ_EN = 7;
    localparam int BIT_IRQ_PEND = 6;
    localparam int BIT_PRIO_LO = 4;
    localparam int BIT_BURST = 3;
    localparam int BIT_WORD_DMA = 2;
    localparam int BIT_DMA_CH1 = 1;
    localparam int BIT_DMA_CH0 = 0;
    localparam int BIT_CTL_ONE = 1;
    localparam int BIT_CTL_ZERO = 0;
    localparam int BIT_MASK_READY = 0;
    localparam int BIT_MASK_EXT = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_CTL = 2'h0;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } byte_req_t;

    typedef struct packed {
        logic ok;
        logic ext_low;
        logic one_low;
        logic zero_low;
    } line_state_t;

endpackage

//--- pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    initial begin
        if (WIDTH < 1) $error("pin_sync width must be positive");
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Per bit, take the new level only when the last two stages agree
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            level <= INIT;
        end else begin
            level <= (s2_q & s3_q) | (level & (s2_q | s3_q));
        end
    end
endmodule // pin_sync

//--- byte_store.sv
// Byte register with a write strobe and a soft clear
`timescale 1ns/1ns
module byte_store #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clear,
    input wire logic load,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] q
);
    initial begin
        if (WIDTH < 1 || WIDTH > 8) $error("byte_store width must be 1 to 8");
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= INIT;
        end else if (clear) begin
            q <= INIT;
        end else if (load) begin
            q <= din;
        end
    end
endmodule // byte_store

//--- parallel_io_byte_registers.sv
// Byte-wide register bank of a 16-bit parallel I/O port
`timescale 1ns/1ns
module parallel_io_byte_registers #(
    // Arbitrary neutral card-type code
    parameter logic [7:0] CARD_TYPE_CODE = 8'h5A
) (
    input wire logic clk,
    input wire logic arst_n,
    input pio_byte_pkg::byte_req_t req,
    output logic [7:0] rdata_q,
    output logic rvalid,
    input wire logic [15:0] data_in_pins,
    output logic [15:0] data_out_q,
    output logic handshake_control_line,
    input wire logic peripheral_flag,
    input wire logic status_input_zero_n,
    input wire logic status_input_one_n,
    input wire logic external_interrupt_line_n,
    input wire logic peripheral_ok_line,
    input wire logic [1:0] irq_priority_switches,
    output logic control_output_zero_n,
    output logic control_output_one_n,
    output logic irq_request,
    output logic [3:0] dma_ctrl
);
    import pio_byte_pkg::*;

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    logic wr_any;
    logic wr_nonzero;
    logic wr_set;
    logic soft_rst;
    logic wr_mask;
    logic wr_ctrl;
    logic wr_high;
    logic wr_low;
    logic wr_lines;

    assign wr_any = req.wr && !req.rd;
    assign wr_nonzero = wr_any && (req.wdata != RST_BYTE);
    // Separate read and write registers share each location except 2, whose read returns zero, 3, whose read returns the written enable and DMA bits, and unused 6
    assign wr_set = wr_nonzero && (req.addr == LOC_READY_SET);
    assign soft_rst = wr_nonzero && (req.addr == LOC_ID_RESET);
    assign wr_mask = wr_any && (req.addr == LOC_MASK);
    assign wr_ctrl = wr_any && (req.addr == LOC_IRQ_DMA);
    assign wr_high = wr_any && (req.addr == LOC_WORD_HIGH);
    assign wr_low = wr_any && (req.addr == LOC_WORD_LOW);
    assign wr_lines = wr_any && (req.addr == LOC_LINES);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [15:0] data_in_s;
    logic [4:0] line_s;
    line_state_t lines;
    logic flag_s;

    pin_sync #(
        .WIDTH(16),
        .INIT(16'h0000)
    ) u_data_sync (
        .clk(clk),
        .arst_n(arst_n),
        .pin(data_in_pins),
        .level(data_in_s)
    );

    pin_sync #(
        .WIDTH(5),
        .INIT(5'h0F)
    ) u_line_sync (
        .clk(clk),
        .arst_n(arst_n),
        .pin({peripheral_flag, peripheral_ok_line, external_interrupt_line_n,
              status_input_one_n, status_input_zero_n}),
        .level(line_s)
    );

    // Line-low flags read as 1 when the line is low
    assign flag_s = line_s[4];
    assign lines.ok = line_s[3];
    assign lines.ext_low = !line_s[2];
    assign lines.one_low = !line_s[1];
    assign lines.zero_low = !line_s[0];

    // ------------------------------------------------------------
    // Writable bytes
    // ------------------------------------------------------------
    logic [7:0] mask_q;
    logic [7:0] ctrl_q;
    logic [7:0] out_high_q;
    logic [7:0] out_low_q;

    byte_store #(
        .WIDTH(8),
        .INIT(RST_BYTE)
    ) u_mask (
        .clk(clk),
        .arst_n(arst_n),
        .clear(soft_rst),
        .load(wr_mask),
        .din(req.wdata),
        .q(mask_q)
    );

    byte_store #(
        .WIDTH(8),
        .INIT(RST_BYTE)
    ) u_ctrl (
        .clk(clk),
        .arst_n(arst_n),
        .clear(soft_rst),
        .load(wr_ctrl),
        .din(req.wdata),
        .q(ctrl_q)
    );

    byte_store #(
        .WIDTH(8),
        .INIT(RST_BYTE)
    ) u_out_high (
        .clk(clk),
        .arst_n(arst_n),
        .clear(soft_rst),
        .load(wr_high),
        .din(req.wdata),
        .q(out_high_q)
    );

    byte_store #(
        .WIDTH(8),
        .INIT(RST_BYTE)
    ) u_out_low (
        .clk(clk),
        .arst_n(arst_n),
        .clear(soft_rst),
        .load(wr_low),
        .din(req.wdata),
        .q(out_low_q)
    );

    assign data_out_q = {out_high_q, out_low_q};
    assign dma_ctrl = ctrl_q[BIT_BURST:BIT_DMA_CH0];

    // ------------------------------------------------------------
    // Control output lines
    // ------------------------------------------------------------
    logic [1:0] ctl_q;

    // Only power-on reset touches these; the soft reset does not
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_q <= RST_CTL;
        end else if (wr_lines) begin
            ctl_q <= req.wdata[BIT_CTL_ONE:BIT_CTL_ZERO];
        end
    end

    assign control_output_zero_n = !ctl_q[BIT_CTL_ZERO];
    assign control_output_one_n = !ctl_q[BIT_CTL_ONE];

    // ------------------------------------------------------------
    // Handshake control line
    // ------------------------------------------------------------
    logic hs_line_q;
    logic flag_d_q;
    logic flag_rise;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_d_q <= 1'b0;
        end else begin
            flag_d_q <= flag_s;
        end
    end

    assign flag_rise = flag_s && !flag_d_q;

    // A set in the same cycle as the peripheral's completion wins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hs_line_q <= 1'b0;
        end else if (soft_rst) begin
            hs_line_q <= 1'b0;
        end else if (wr_set) begin
            hs_line_q <= 1'b1;
        end else if (flag_rise) begin
            hs_line_q <= 1'b0;
        end
    end

    assign handshake_control_line = hs_line_q;

    // ------------------------------------------------------------
    // Ready and interrupt
    // ------------------------------------------------------------
    logic ready;
    logic irq_pend;

    assign ready = !hs_line_q;
    assign irq_pend = (mask_q[BIT_MASK_READY] && ready)
        || (mask_q[BIT_MASK_EXT] && lines.ext_low);
    assign irq_request = ctrl_q[BIT_IRQ_EN] && irq_pend;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = READ_ZERO;
        unique case (req.addr)
            LOC_READY_SET: rdata_d = {7'h00, ready};
            LOC_ID_RESET: rdata_d = CARD_TYPE_CODE;
            LOC_MASK: rdata_d = READ_ZERO;
            LOC_IRQ_DMA: rdata_d = {ctrl_q[BIT_IRQ_EN], irq_request,
                irq_priority_switches, ctrl_q[BIT_BURST:BIT_DMA_CH0]};
            LOC_WORD_HIGH: rdata_d = data_in_s[15:8];
            LOC_WORD_LOW: rdata_d = data_in_s[7:0];
            LOC_UNUSED: rdata_d = READ_ZERO;
            LOC_LINES: rdata_d = {4'h0, lines};
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= READ_ZERO;
        end else if (req.rd) begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_ready_read: assert property (@(posedge clk) disable iff (!arst_n)
        (req.rd && req.addr == LOC_READY_SET) |=> (rdata_q == {7'h00, !$past(hs_line_q)}))
        else $error("ready byte does not follow handshake state");

    chk_card_code: assert property (@(posedge clk) disable iff (!arst_n)
        (req.rd && req.addr == LOC_ID_RESET) |=> (rdata_q == CARD_TYPE_CODE))
        else $error("card code read wrong");

    chk_irq_status: assert property (@(posedge clk) disable iff (!arst_n)
        (req.rd && req.addr == LOC_IRQ_DMA)
        |=> (rdata_q[BIT_IRQ_EN] == $past(ctrl_q[BIT_IRQ_EN])
             && rdata_q[BIT_IRQ_PEND] == $past(irq_request)
             && rdata_q[BIT_PRIO_LO+1:BIT_PRIO_LO] == $past(irq_priority_switches)
             && rdata_q[BIT_BURST:BIT_DMA_CH0] == $past(ctrl_q[BIT_BURST:BIT_DMA_CH0])))
        else $error("irq status byte wrong");

    chk_word_high: assert property (@(posedge clk) disable iff (!arst_n)
        (req.rd && req.addr == LOC_WORD_HIGH) |=> (rdata_q == $past(data_in_s[15:8])))
        else $error("input high byte wrong");

    chk_word_low: assert property (@(posedge clk) disable iff (!arst_n)
        (req.rd && req.addr == LOC_WORD_LOW) |=> (rdata_q == $past(data_in_s[7:0])))
        else $error("input low byte wrong");

    chk_out_high: assert property (@(posedge clk) disable iff (!arst_n)
        wr_high && !soft_rst |=> (data_out_q[15:8] == $past(req.wdata)))
        else $error("output high byte not loaded");

    chk_out_low: assert property (@(posedge clk) disable iff (!arst_n)
        wr_low |=> (data_out_q[7:0] == $past(req.wdata)))
        else $error("output low byte not loaded");

    chk_hs_set: assert property (@(posedge clk) disable iff (!arst_n)
        wr_set |=> handshake_control_line)
        else $error("handshake line not set");

    chk_hs_zero: assert property (@(posedge clk) disable iff (!arst_n)
        (wr_any && req.addr == LOC_READY_SET && req.wdata == RST_BYTE && !flag_rise)
        |=> $stable(handshake_control_line))
        else $error("zero write moved handshake line");

    chk_soft_reset: assert property (@(posedge clk) disable iff (!arst_n)
        soft_rst |=> (data_out_q == 16'h0000 && !handshake_control_line && ctrl_q == RST_BYTE))
        else $error("interface reset incomplete");

    chk_ctl_drive: assert property (@(posedge clk) disable iff (!arst_n)
        wr_lines |=> (control_output_one_n == !$past(req.wdata[1])
                      && control_output_zero_n == !$past(req.wdata[0])))
        else $error("control lines wrong");

    chk_ctl_keep: assert property (@(posedge clk) disable iff (!arst_n)
        soft_rst |=> $stable(ctl_q))
        else $error("interface reset moved control lines");

    chk_line_bits: assert property (@(posedge clk) disable iff (!arst_n)
        (req.rd && req.addr == LOC_LINES) |=> (rdata_q[7:4] == 4'h0
            && rdata_q[0] == !$past(line_s[0])))
        else $error("peripheral status byte wrong");

    chk_undef_zero: assert property (@(posedge clk) disable iff (!arst_n)
        (req.rd && (req.addr == LOC_UNUSED || req.addr == LOC_MASK)) |=> (rdata_q == 8'h00))
        else $error("undefined location not zero");

    chk_undef_write: assert property (@(posedge clk) disable iff (!arst_n)
        (wr_any && req.addr == LOC_UNUSED) |=> ($stable(data_out_q) && $stable(ctl_q)
            && $stable(mask_q) && $stable(ctrl_q)))
        else $error("write to undefined location had effect");

    chk_mask_load: assert property (@(posedge clk) disable iff (!arst_n)
        wr_mask |=> (mask_q == $past(req.wdata)))
        else $error("interrupt mask not loaded");

    chk_dma_load: assert property (@(posedge clk) disable iff (!arst_n)
        wr_ctrl |=> (dma_ctrl == $past(req.wdata[BIT_BURST:BIT_DMA_CH0])))
        else $error("dma control not loaded");

    chk_hs_done: assert property (@(posedge clk) disable iff (!arst_n)
        (flag_rise && !wr_set) |=> !handshake_control_line)
        else $error("handshake line not cleared on completion");

    chk_line_live: assert property (@(posedge clk) disable iff (!arst_n)
        (req.rd && req.addr == LOC_LINES) |=> (rdata_q[3:0] == $past(lines)))
        else $error("peripheral status not live");

    chk_ctl_hold: assert property (@(posedge clk) disable iff (!arst_n)
        !wr_lines |=> $stable(ctl_q))
        else $error("control lines moved without a write");

    chk_clash_read: assert property (@(posedge clk) disable iff (!arst_n)
        (req.rd && req.wr) |=> ($stable(data_out_q) && $stable(mask_q) && $stable(ctrl_q)
            && $stable(ctl_q)))
        else $error("read with write strobe changed a register");

    chk_rdata_hold: assert property (@(posedge clk) disable iff (!arst_n)
        !req.rd |=> ($stable(rdata_q) && !rvalid))
        else $error("read data moved without a read");

    cov_set_then_done: cover property (@(posedge clk) disable iff (!arst_n)
        wr_set ##[1:50] flag_rise);
    cov_soft_reset: cover property (@(posedge clk) disable iff (!arst_n) soft_rst);
    cov_irq: cover property (@(posedge clk) disable iff (!arst_n) $rose(irq_request));
    cov_clash_read: cover property (@(posedge clk) disable iff (!arst_n) req.rd && req.wr);
endmodule // parallel_io_byte_registers

//--- pio_peripheral_model.sv
// Behavioural peripheral on the far side of the parallel handshake port
`timescale 1ns/1ns
module pio_peripheral_model (
    input wire logic clk,
    input wire logic handshake_control_line,
    input wire logic [15:0] word,
    input wire logic [3:0] lines,
    input wire logic [7:0] delay,
    output logic [15:0] data_in_pins,
    output logic peripheral_flag,
    output logic status_input_zero_n,
    output logic status_input_one_n,
    output logic external_interrupt_line_n,
    output logic peripheral_ok_line
);
    int wait_cnt = 0;

    // ------------------------------------------------------------
    // Line levels, lines = {ok, ext low, one low, zero low}
    // ------------------------------------------------------------
    assign data_in_pins = word;
    assign peripheral_ok_line = lines[3];
    assign external_interrupt_line_n = ~lines[2];
    assign status_input_one_n = ~lines[1];
    assign status_input_zero_n = ~lines[0];

    // ------------------------------------------------------------
    // Done flag raised delay cycles after the line is first seen high, held until the line drops
    // ------------------------------------------------------------
    initial peripheral_flag = 1'b0;
    always @(posedge clk) begin
        if (!handshake_control_line) begin
            wait_cnt <= 0;
            peripheral_flag <= 1'b0;
        end else if (wait_cnt == int'(delay)) begin
            peripheral_flag <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end
endmodule // pio_peripheral_model

//--- parallel_io_byte_registers_tb.sv
// Self-checking testbench of the parallel I/O byte register bank
`timescale 1ns/1ns
module parallel_io_byte_registers_tb;
    import pio_byte_pkg::*;
    // Arbitrary card-type code for this bench
    localparam logic [7:0] CARD_CODE = 8'h6C;

    logic clk = 1'b0;
    logic arst_n = 1'b0;
    byte_req_t req = '0;
    logic [7:0] rdata_q;
    logic rvalid;
    logic [15:0] data_in_pins;
    logic [15:0] data_out_q;
    logic handshake_control_line;
    logic peripheral_flag;
    logic status_input_zero_n;
    logic status_input_one_n;
    logic external_interrupt_line_n;
    logic peripheral_ok_line;
    logic [1:0] irq_priority_switches = 2'h2;
    logic control_output_zero_n;
    logic control_output_one_n;
    logic irq_request;
    logic [3:0] dma_ctrl;
    logic [15:0] word = 16'h0000;
    logic [3:0] lines = 4'h8;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc_cnt = 0;

    always #50 clk = ~clk;

    parallel_io_byte_registers #(.CARD_TYPE_CODE(CARD_CODE)) i_parallel_io_byte_registers (
        .clk(clk), .arst_n(arst_n), .req(req), .rdata_q(rdata_q), .rvalid(rvalid),
        .data_in_pins(data_in_pins), .data_out_q(data_out_q),
        .handshake_control_line(handshake_control_line), .peripheral_flag(peripheral_flag),
        .status_input_zero_n(status_input_zero_n), .status_input_one_n(status_input_one_n),
        .external_interrupt_line_n(external_interrupt_line_n),
        .peripheral_ok_line(peripheral_ok_line), .irq_priority_switches(irq_priority_switches),
        .control_output_zero_n(control_output_zero_n),
        .control_output_one_n(control_output_one_n), .irq_request(irq_request),
        .dma_ctrl(dma_ctrl));

    pio_peripheral_model i_pio_peripheral_model (
        .clk(clk), .handshake_control_line(handshake_control_line), .word(word),
        .lines(lines), .delay(8'h14), .data_in_pins(data_in_pins),
        .peripheral_flag(peripheral_flag), .status_input_zero_n(status_input_zero_n),
        .status_input_one_n(status_input_one_n),
        .external_interrupt_line_n(external_interrupt_line_n),
        .peripheral_ok_line(peripheral_ok_line));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] addr, input logic [7:0] data);
        @(negedge clk);
        req = '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
        @(negedge clk);
        req = '0;
    endtask

    // Read one byte and check it together with the valid pulse
    task automatic rd_chk(input logic [2:0] addr, input logic [7:0] exp);
        @(negedge clk);
        req = '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
        @(negedge clk);
        req = '0;
        chk_word({7'h00, rvalid, rdata_q}, {8'h01, exp});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_state();
        rd_chk(LOC_READY_SET, 8'h01);
        rd_chk(LOC_ID_RESET, CARD_CODE);
        rd_chk(LOC_MASK, 8'h00);
        rd_chk(LOC_UNUSED, 8'h00);
        chk_word({14'h0, control_output_one_n, control_output_zero_n}, 16'h0003);
    endtask

    task automatic t_data_out();
        wr(LOC_WORD_HIGH, 8'hA5);
        wr(LOC_WORD_LOW, 8'h3C);
        chk_word(data_out_q, 16'hA53C);
        wr(LOC_WORD_LOW, 8'hC1);
        chk_word(data_out_q, 16'hA5C1);
        wr(LOC_UNUSED, 8'hFF);
        chk_word(data_out_q, 16'hA5C1);
    endtask

    task automatic t_data_in();
        word = 16'h8137;
        repeat (8) @(negedge clk);
        rd_chk(LOC_WORD_HIGH, 8'h81);
        rd_chk(LOC_WORD_LOW, 8'h37);
        @(negedge clk);
        req = '{rd: 1'b1, wr: 1'b1, addr: LOC_WORD_HIGH, wdata: 8'h00};
        @(negedge clk);
        req = '0;
        chk_word({7'h00, rvalid, rdata_q}, 16'h0181);
        chk_word(data_out_q, 16'hA5C1);
    endtask

    task automatic t_handshake();
        int n;
        wr(LOC_READY_SET, 8'h00);
        chk_word({15'h0, handshake_control_line}, 16'h0000);
        wr(LOC_READY_SET, 8'h40);
        chk_word({15'h0, handshake_control_line}, 16'h0001);
        rd_chk(LOC_READY_SET, 8'h00);
        for (n = 0; n < 60 && handshake_control_line !== 1'b0; n++) begin
            @(negedge clk);
        end
        chk_word({15'h0, handshake_control_line}, 16'h0000);
        rd_chk(LOC_READY_SET, 8'h01);
    endtask

    task automatic t_irq_dma();
        wr(LOC_IRQ_DMA, 8'h8F);
        chk_word({12'h0, dma_ctrl}, 16'h000F);
        rd_chk(LOC_IRQ_DMA, 8'hAF);
        wr(LOC_MASK, 8'h01);
        chk_word({15'h0, irq_request}, 16'h0001);
        rd_chk(LOC_IRQ_DMA, 8'hEF);
        wr(LOC_IRQ_DMA, 8'h05);
        chk_word({11'h0, irq_request, dma_ctrl}, 16'h0005);
    endtask

    task automatic t_lines();
        logic [3:0] tbl [4] = '{4'h0, 4'h9, 4'h6, 4'hF};
        foreach (tbl[i]) begin
            lines = tbl[i];
            repeat (6) @(negedge clk);
            rd_chk(LOC_LINES, {4'h0, tbl[i]});
        end
        lines = 4'h8;
        repeat (6) @(negedge clk);
        rd_chk(LOC_LINES, 8'h08);
    endtask

    task automatic t_controls();
        wr(LOC_LINES, 8'hFE);
        chk_word({14'h0, control_output_one_n, control_output_zero_n}, 16'h0001);
        wr(LOC_LINES, 8'h01);
        chk_word({14'h0, control_output_one_n, control_output_zero_n}, 16'h0002);
        wr(LOC_ID_RESET, 8'h00);
        chk_word(data_out_q, 16'hA5C1);
        wr(LOC_ID_RESET, 8'h10);
        chk_word(data_out_q, 16'h0000);
        chk_word({14'h0, control_output_one_n, control_output_zero_n}, 16'h0002);
        rd_chk(LOC_IRQ_DMA, 8'h20);
    endtask

    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            error_cnt++;
            $display("[FAIL] %0t run did not finish in time", $time);
            give_verdict();
        end
    end

    initial begin
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        t_reset_state();
        t_data_out();
        t_data_in();
        t_handshake();
        t_irq_dma();
        t_lines();
        t_controls();
        give_verdict();
    end
endmodule // parallel_io_byte_registers_tb
